// ### icsm_irq_ctrl.sv
// Interrupt flag and enable bank with the supply-monitor digital front end.
// Assumes pins and the comparator are asynchronous; events, sleep and idle
// come from logic on the same clock.
`timescale 1ns/1ps
module icsm_irq_ctrl
(
   input  wire logic                   clock,
   input  wire logic                   sys_rst,
   input  wire icsm_pkg::icsm_axi_req_type axi_req,
   output icsm_pkg::icsm_axi_rsp_type  axi_rsp,
   input  wire icsm_pkg::icsm_evt_type periph_evt,
   input  wire logic                   ext_pin_a,
   input  wire logic                   ext_pin_b,
   input  wire logic                   low_supply_raw,
   input  wire logic                   low_supply_reset_en,
   input  wire logic                   sleep_mode,
   input  wire logic                   idle_mode,
   output icsm_pkg::icsm_mon_type      mon_out,
   output logic [10:0]                 irq_pending,
   output logic                        core_irq,
   output logic                        wake_idle
);
   import icsm_pkg::*;

   icsm_state_type st_r;
   icsm_state_type st_nxt;

   logic                  aw_hs;
   logic                  w_hs;
   logic                  ar_hs;
   logic                  ar_ok;
   logic [3:0]            ar_idx;
   logic                  do_wr;
   logic                  mon_evt;
   logic                  pin_a_evt;
   logic                  pin_b_evt;
   logic [3:0]            mf_any;
   logic [NUM_REGS-1:0][7:0] set_vec;
   logic [7:0]            wr_base;
   logic [7:0]            rd_byte;

   // ********************************
   // Edge select decode
   // ********************************
   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic       cur,
                                     input logic       prev);
      logic rise;
      logic fall;
      rise = cur & ~prev;
      fall = ~cur & prev;
      unique case (sel)
         EDGE_OFF:  edge_hit = 1'h0;
         EDGE_RISE: edge_hit = rise;
         EDGE_FALL: edge_hit = fall;
         EDGE_BOTH: edge_hit = rise | fall;
      endcase
   endfunction : edge_hit

   // ********************************
   // Next state
   // ********************************
   always_comb
   begin
      st_nxt = st_r;

      st_nxt.pin_a_sync = {st_r.pin_a_sync[0], ext_pin_a};
      st_nxt.pin_b_sync = {st_r.pin_b_sync[0], ext_pin_b};
      st_nxt.low_sync   = {st_r.low_sync[0], low_supply_raw};
      st_nxt.pin_a_prev = st_r.pin_a_sync[1];
      st_nxt.pin_b_prev = st_r.pin_b_sync[1];

      pin_b_evt = edge_hit(st_r.regs[IDX_EDGE][3:2],
                           st_r.pin_b_sync[1], st_r.pin_b_prev);
      pin_a_evt = edge_hit(st_r.regs[IDX_EDGE][1:0],
                           st_r.pin_a_sync[1], st_r.pin_a_prev);

      st_nxt.low_status = st_r.mon.monitor_active & st_r.low_sync[1];

      if (!st_r.low_status)
      begin
         st_nxt.dly_cnt = '0;
      end
      else if (st_r.dly_cnt != MON_DLY_FULL)
      begin
         st_nxt.dly_cnt = st_r.dly_cnt + MON_CNT_W'(1);
      end
      mon_evt = st_r.low_status && (st_r.dly_cnt == MON_DLY_LAST);

      for (int k = 0; k < 4; k++)
      begin
         mf_any[k] = |(st_r.regs[int'(IDX_GRP_A) + k][7:4] &
                       st_r.regs[int'(IDX_GRP_A) + k][3:0]);
      end

      set_vec = '0;
      set_vec[IDX_PRIM_A] = {1'h0, periph_evt.touch, pin_b_evt,
                             pin_a_evt, 4'h0};
      set_vec[IDX_PRIM_B] = {periph_evt.adc, mf_any[1], mf_any[0],
                             periph_evt.uart, 4'h0};
      set_vec[IDX_PRIM_C] = {mf_any[3], periph_evt.tb1, periph_evt.tb0,
                             mf_any[2], 4'h0};
      set_vec[IDX_GRP_A]  = {2'h0, periph_evt.ctm0a, periph_evt.ctm0p,
                             4'h0};
      set_vec[IDX_GRP_B]  = {periph_evt.stma, periph_evt.stmp,
                             periph_evt.ctm1a, periph_evt.ctm1p, 4'h0};
      set_vec[IDX_GRP_C]  = {1'h0, periph_evt.sim, periph_evt.ptma,
                             periph_evt.ptmp, 4'h0};
      set_vec[IDX_GRP_D]  = {2'h0, periph_evt.eeprom, mon_evt, 4'h0};

      // AXI write channel.
      aw_hs = axi_req.awvalid && st_r.rsp.awready;
      w_hs  = axi_req.wvalid && st_r.rsp.wready;
      // word index past the map is refused
      if (aw_hs)
      begin
         st_nxt.aw_got = 1'h1;
         st_nxt.aw_idx = axi_req.awaddr[5:2];
         st_nxt.aw_bad = axi_req.awaddr[31:2] >= 30'(NUM_REGS);
      end
      if (w_hs)
      begin
         st_nxt.w_got  = 1'h1;
         st_nxt.w_byte = axi_req.wdata[7:0];
         st_nxt.w_lane = axi_req.wstrb[0];
      end
      do_wr = 1'h0;
      if (st_r.aw_got && st_r.w_got && !st_r.rsp.bvalid)
      begin
         do_wr = !st_r.aw_bad && st_r.w_lane;
         st_nxt.aw_got = 1'h0;
         st_nxt.w_got  = 1'h0;
         st_nxt.rsp.bvalid = 1'h1;
         st_nxt.rsp.bresp  = st_r.aw_bad ? RESP_SLVERR : RESP_OKAY;
      end
      else if (st_r.rsp.bvalid && axi_req.bready)
      begin
         st_nxt.rsp.bvalid = 1'h0;
      end

      for (int i = 0; i < NUM_REGS; i++)
      begin
         wr_base = (do_wr && st_r.aw_idx == 4'(i)) ? st_r.w_byte
                                                   : st_r.regs[i];
         st_nxt.regs[i] = (wr_base | set_vec[i]) & IMPL_MASK[i];
      end

      // AXI read channel.
      ar_hs  = axi_req.arvalid && st_r.rsp.arready;
      ar_idx = axi_req.araddr[5:2];
      ar_ok  = axi_req.araddr[31:2] < 30'(NUM_REGS);
      rd_byte = REG_RESET;
      if (ar_ok)
      begin
         rd_byte = (ar_idx == IDX_MON)
                 ? {2'h0, st_r.low_status, st_r.regs[IDX_MON][4:0]}
                 : st_r.regs[ar_idx];
      end
      if (ar_hs)
      begin
         st_nxt.rsp.rvalid = 1'h1;
         st_nxt.rsp.rdata  = {24'h0, rd_byte};
         st_nxt.rsp.rresp  = ar_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (st_r.rsp.rvalid && axi_req.rready)
      begin
         st_nxt.rsp.rvalid = 1'h0;
      end
      // One write and one read at a time keeps the response path simple;
      // the price is a few idle cycles between back-to-back writes.
      st_nxt.rsp.awready = !st_nxt.aw_got && !st_nxt.rsp.bvalid;
      st_nxt.rsp.wready  = !st_nxt.w_got && !st_nxt.rsp.bvalid;
      st_nxt.rsp.arready = !st_nxt.rsp.rvalid;

      st_nxt.mon.threshold_select = st_r.regs[IDX_MON][THR_MSB:0];
      st_nxt.mon.monitor_active = st_r.regs[IDX_MON][MON_EN_BIT] &
                                  ~sleep_mode;
      st_nxt.mon.reference_buffer_enable =
         st_r.regs[IDX_MON][MON_EN_BIT] | low_supply_reset_en |
         st_r.regs[IDX_MON][MON_BUF_BIT];

      st_nxt.pending = {
         st_r.regs[IDX_PRIM_C][7:4] & st_r.regs[IDX_PRIM_C][3:0],
         st_r.regs[IDX_PRIM_B][7:4] & st_r.regs[IDX_PRIM_B][3:0],
         st_r.regs[IDX_PRIM_A][6:4] & st_r.regs[IDX_PRIM_A][3:1]};
      st_nxt.core_irq = st_r.regs[IDX_PRIM_A][GLOBAL_EN_BIT] &
                        (|st_nxt.pending);

      st_nxt.wake = idle_mode && mon_evt &&
                    !st_r.regs[IDX_GRP_D][MON_FLAG_BIT];
   end

   // ********************************
   // State register
   // ********************************
   // Synchronous reset leaves ready low for one cycle after release.
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign axi_rsp     = st_r.rsp;
   assign mon_out     = st_r.mon;
   assign irq_pending = st_r.pending;
   assign core_irq    = st_r.core_irq;
   assign wake_idle   = st_r.wake;

   // ********************************
   // Checks
   // ********************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   thr_follow_a : assert property (
      (do_wr && st_r.aw_idx == IDX_MON) |=> ##1
      mon_out.threshold_select == $past(st_r.w_byte[THR_MSB:0], 2))
      else $error("threshold output does not follow write");

   status_read_a : assert property (
      (ar_hs && ar_ok && ar_idx == IDX_MON) |=>
      axi_rsp.rdata[MON_STATUS_BIT] == $past(st_r.low_status))
      else $error("status bit read wrong");

   enable_on_a : assert property (
      $rose(mon_out.monitor_active) |->
      $past(st_r.regs[IDX_MON][MON_EN_BIT]) && !$past(sleep_mode))
      else $error("monitor active without enable");

   buf_on_a : assert property (
      (low_supply_reset_en || st_r.regs[IDX_MON][MON_BUF_BIT]) |=>
      mon_out.reference_buffer_enable)
      else $error("reference buffer not enabled");

   sleep_off_a : assert property (
      sleep_mode |=> !mon_out.monitor_active ##1 !st_r.low_status)
      else $error("monitor active in sleep");

   irq_delay_a : assert property (
      $rose(st_r.low_status) |->
      !mon_evt [*8])
      else $error("monitor request before its delay");

   wake_idle_a : assert property (
      (idle_mode && mon_evt && !st_r.regs[IDX_GRP_D][MON_FLAG_BIT]) |=>
      wake_idle && st_r.regs[IDX_GRP_D][MON_FLAG_BIT])
      else $error("no wake on monitor request");

   mon_upper_a : assert property (
      (ar_hs && ar_idx == IDX_MON) |=> axi_rsp.rdata[31:6] == 26'h0)
      else $error("monitor upper bits not zero");

   edge_upper_a : assert property (
      (ar_hs && ar_idx == IDX_EDGE) |=> axi_rsp.rdata[31:4] == 28'h0)
      else $error("edge register upper bits not zero");

   global_gate_a : assert property (
      !st_r.regs[IDX_PRIM_A][GLOBAL_EN_BIT] |=> !core_irq)
      else $error("request passed with global enable off");

   group_set_a : assert property (
      (|(st_r.regs[IDX_GRP_A][7:4] & st_r.regs[IDX_GRP_A][3:0])) |=>
      st_r.regs[IDX_PRIM_B][MF0_FLAG_BIT])
      else $error("grouped flag not set");

   pin_rise_a : assert property (
      ($rose(st_r.pin_a_sync[1]) && st_r.regs[IDX_EDGE][1:0] == EDGE_RISE)
      |=> st_r.regs[IDX_PRIM_A][PIN_A_FLAG_BIT])
      else $error("pin a rising edge missed");

   pin_fall_a : assert property (
      ($fell(st_r.pin_b_sync[1]) && st_r.regs[IDX_EDGE][3:2] == EDGE_FALL)
      |=> st_r.regs[IDX_PRIM_A][PIN_B_FLAG_BIT])
      else $error("pin b falling edge missed");

   mon_sub_a : assert property (
      mon_evt |=> st_r.regs[IDX_GRP_D][MON_FLAG_BIT])
      else $error("monitor request not in grouped register");

   core_level_a : assert property (
      core_irq == ((|irq_pending) &&
                   $past(st_r.regs[IDX_PRIM_A][GLOBAL_EN_BIT])))
      else $error("core request does not match enabled flags");

   edge_write_a : assert property (
      (do_wr && st_r.aw_idx == IDX_EDGE) |=>
      st_r.regs[IDX_EDGE] == ($past(st_r.w_byte) & IMPL_MASK[IDX_EDGE]))
      else $error("edge select write lost");

   // The synchronisers refill for two cycles after reset, so skip those.
   pin_sync_a : assert property (
      (!$past(sys_rst) && !$past(sys_rst, 2)) |->
      st_r.pin_b_sync[1] == $past(ext_pin_b, 2))
      else $error("pin b synchroniser skipped a stage");

   status_off_a : assert property (
      !mon_out.monitor_active |=> !st_r.low_status)
      else $error("status set while detector off");

   status_follow_a : assert property (
      mon_out.monitor_active |=> st_r.low_status == $past(st_r.low_sync[1]))
      else $error("status does not follow comparator");

   buf_off_a : assert property (
      !(st_r.regs[IDX_MON][MON_EN_BIT] || low_supply_reset_en ||
        st_r.regs[IDX_MON][MON_BUF_BIT]) |=>
      !mon_out.reference_buffer_enable)
      else $error("reference buffer on with no cause");

   no_wake_a : assert property (
      !idle_mode |=> !wake_idle)
      else $error("wake pulse outside idle");

   rd_refuse_a : assert property (
      (ar_hs && !ar_ok) |=>
      axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0)
      else $error("unmapped read not refused");

   wr_refuse_a : assert property (
      (st_r.aw_got && st_r.w_got && !st_r.rsp.bvalid && st_r.aw_bad) |=>
      axi_rsp.bvalid && axi_rsp.bresp == RESP_SLVERR)
      else $error("unmapped write not refused");

   mon_req_c : cover property (mon_evt ##1 core_irq);
   both_edge_c : cover property (
      st_r.regs[IDX_EDGE][3:2] == EDGE_BOTH && pin_b_evt);
   axi_wr_c : cover property (do_wr ##1 axi_rsp.bvalid);
   wake_c : cover property (wake_idle);
   slverr_c : cover property (ar_hs && !ar_ok);

endmodule : icsm_irq_ctrl

// ### icsm_pkg.sv
// Constants and carrier types for the interrupt controller with its
// supply-monitor front end.
// Assumes a 250 MHz system clock and an AXI4-Lite master with 32-bit data.
package icsm_pkg;

   // ********************************
   // Timing
   // ********************************
   localparam int unsigned CLK_MHZ          = 250;
   localparam int unsigned MON_IRQ_DELAY_NS = 200;
   localparam int unsigned MON_DLY_CYC      =
      (MON_IRQ_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned MON_CNT_W        = $clog2(MON_DLY_CYC + 1);
   localparam logic [MON_CNT_W-1:0] MON_DLY_LAST = MON_CNT_W'(MON_DLY_CYC - 1);
   localparam logic [MON_CNT_W-1:0] MON_DLY_FULL = MON_CNT_W'(MON_DLY_CYC);

   // ********************************
   // Register map, byte address is four times the index
   // ********************************
   localparam int unsigned NUM_REGS   = 9;
   localparam logic [3:0]  IDX_MON    = 4'h0;
   localparam logic [3:0]  IDX_EDGE   = 4'h1;
   localparam logic [3:0]  IDX_PRIM_A = 4'h2;
   localparam logic [3:0]  IDX_PRIM_B = 4'h3;
   localparam logic [3:0]  IDX_PRIM_C = 4'h4;
   localparam logic [3:0]  IDX_GRP_A  = 4'h5;
   localparam logic [3:0]  IDX_GRP_B  = 4'h6;
   localparam logic [3:0]  IDX_GRP_C  = 4'h7;
   localparam logic [3:0]  IDX_GRP_D  = 4'h8;
   localparam logic [7:0]  IMPL_MASK [NUM_REGS] = '{
      8'h1F, 8'h0F, 8'h7F, 8'hFF, 8'hFF, 8'h33, 8'hFF, 8'h77, 8'h33};
   localparam logic [7:0]  REG_RESET  = 8'h00;

   // ********************************
   // Field positions
   // ********************************
   localparam int unsigned MON_STATUS_BIT = 5;
   localparam int unsigned MON_EN_BIT     = 4;
   localparam int unsigned MON_BUF_BIT    = 3;
   localparam int unsigned THR_MSB        = 2;
   localparam int unsigned GLOBAL_EN_BIT  = 0;
   localparam int unsigned PIN_A_FLAG_BIT = 4;
   localparam int unsigned PIN_B_FLAG_BIT = 5;
   localparam int unsigned MON_FLAG_BIT   = 4;
   localparam int unsigned MF0_FLAG_BIT   = 5;
   localparam int unsigned NUM_PRIMARY    = 11;

   localparam logic [1:0] EDGE_OFF  = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ********************************
   // Carrier types
   // ********************************
   typedef struct packed {
      logic        awvalid;
      logic [31:0] awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [31:0] araddr;
      logic        rready;
   } icsm_axi_req_type;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } icsm_axi_rsp_type;

   typedef struct packed {
      logic touch;
      logic uart;
      logic adc;
      logic tb0;
      logic tb1;
      logic ctm0p;
      logic ctm0a;
      logic ctm1p;
      logic ctm1a;
      logic stmp;
      logic stma;
      logic ptmp;
      logic ptma;
      logic sim;
      logic eeprom;
   } icsm_evt_type;

   typedef struct packed {
      logic       monitor_active;
      logic       reference_buffer_enable;
      logic [2:0] threshold_select;
   } icsm_mon_type;

   typedef struct packed {
      logic [NUM_REGS-1:0][7:0] regs;
      logic [1:0]               pin_a_sync;
      logic [1:0]               pin_b_sync;
      logic [1:0]               low_sync;
      logic                     pin_a_prev;
      logic                     pin_b_prev;
      logic                     low_status;
      logic [MON_CNT_W-1:0]     dly_cnt;
      logic                     aw_got;
      logic                     aw_bad;
      logic [3:0]               aw_idx;
      logic                     w_got;
      logic                     w_lane;
      logic [7:0]               w_byte;
      icsm_axi_rsp_type         rsp;
      icsm_mon_type             mon;
      logic [NUM_PRIMARY-1:0]   pending;
      logic                     core_irq;
      logic                     wake;
   } icsm_state_type;

endpackage : icsm_pkg

// ### icsm_src_model.sv
// Far-side model: peripheral event sources, pins and supply comparator.
// Assumes the bench commands it on the same clock as the block.
`timescale 1ns/1ps
module icsm_src_model
(
   input  wire logic                   clock,
   input  wire logic                   sys_rst,
   input  wire icsm_pkg::icsm_evt_type evt_cmd,
   input  wire logic                   pin_a_cmd,
   input  wire logic                   pin_b_cmd,
   input  wire logic                   low_cmd,
   output icsm_pkg::icsm_evt_type      periph_evt,
   output logic                        ext_pin_a,
   output logic                        ext_pin_b,
   output logic                        low_supply_raw
);
   import icsm_pkg::*;
   // ****************
   // Sources
   // ****************
   icsm_evt_type evt_prev_r;
   always_ff @(posedge clock)
      evt_prev_r <= sys_rst ? '0 : evt_cmd;
   // One-shot events.
   // A held command gives one pulse, so a level never re-sets a flag.
   assign periph_evt = evt_cmd & ~evt_prev_r;
   assign ext_pin_a      = pin_a_cmd;
   assign ext_pin_b      = pin_b_cmd;
   assign low_supply_raw = low_cmd;
endmodule : icsm_src_model

// ### irq_ctrl_with_supply_monitor_tb.sv
// Self-checking bench for the interrupt bank and supply-monitor front end.
// Assumes the package and the far-side model are compiled before it.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
$display("unexpected at %0t got %0h expected %0h", $time, g, e); end end
module irq_ctrl_with_supply_monitor_tb;
   import icsm_pkg::*;
   // ****************
   // Signals
   // ****************
   localparam int SETTLE_CYC = 25;
   localparam logic [19:0] ROWS [18] = '{
      20'h0FF1F, 20'h1FF0F, 20'h2FF7F, 20'h3FFFF, 20'h4FFFF, 20'h5FF33,
      20'h6FFFF, 20'h7FF77, 20'h8FF33, 20'h50000, 20'h60000, 20'h70000,
      20'h80000, 20'h20000, 20'h30000, 20'h40000, 20'h10000, 20'h00000};
   localparam logic [11:0] EVS [15] = '{12'h240, 12'h310, 12'h380,
      12'h420, 12'h440, 12'h510, 12'h520, 12'h610, 12'h620, 12'h640,
      12'h680, 12'h710, 12'h720, 12'h740, 12'h820};
   logic             clock = 1'b0;
   logic             sys_rst = 1'b1;
   icsm_axi_req_type req = '0;
   icsm_axi_rsp_type rsp;
   icsm_evt_type     evt_cmd = '0;
   icsm_evt_type     periph_evt;
   icsm_mon_type     mon;
   logic             pin_a_cmd = 1'b0;
   logic             pin_b_cmd = 1'b0;
   logic             low_cmd = 1'b0;
   logic             lsr_en = 1'b0;
   logic             sleep = 1'b0;
   logic             idle = 1'b0;
   logic             pin_a;
   logic             pin_b;
   logic             low_raw;
   logic [10:0]      pend;
   logic             core_irq;
   logic             wake;
   logic [31:0]      rd_d;
   logic [1:0]       rd_resp;
   logic [7:0]       wd;
   int               bad_count = 0;
   int               cmp_count = 0;
   int               wake_cnt = 0;
   int               n_cyc;
   int               w0;

   always #2 clock = ~clock;
   always @(posedge clock)
      if (wake === 1'b1)
         wake_cnt <= wake_cnt + 1;

   icsm_irq_ctrl icsm_irq_ctrl_inst
   (
      .clock               (clock),
      .sys_rst             (sys_rst),
      .axi_req             (req),
      .axi_rsp             (rsp),
      .periph_evt          (periph_evt),
      .ext_pin_a           (pin_a),
      .ext_pin_b           (pin_b),
      .low_supply_raw      (low_raw),
      .low_supply_reset_en (lsr_en),
      .sleep_mode          (sleep),
      .idle_mode           (idle),
      .mon_out             (mon),
      .irq_pending         (pend),
      .core_irq            (core_irq),
      .wake_idle           (wake)
   );
   icsm_src_model icsm_src_model_inst
   (
      .clock          (clock),
      .sys_rst        (sys_rst),
      .evt_cmd        (evt_cmd),
      .pin_a_cmd      (pin_a_cmd),
      .pin_b_cmd      (pin_b_cmd),
      .low_cmd        (low_cmd),
      .periph_evt     (periph_evt),
      .ext_pin_a      (pin_a),
      .ext_pin_b      (pin_b),
      .low_supply_raw (low_raw)
   );
   // ****************
   // Tasks
   // ****************
   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim
   task automatic to_fail();
      bad_count++;
      $display("unexpected at %0t got 0 expected 1", $time);
      end_sim();
   endtask : to_fail
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask : tick
   task automatic axi_wr(input logic [3:0] idx, input logic [7:0] d);
      @(posedge clock);
      req.awvalid <= 1'b1;
      req.awaddr  <= {26'h0, idx, 2'h0};
      req.wvalid  <= 1'b1;
      req.wdata   <= {24'h0, d};
      req.wstrb   <= 4'hF;
      req.bready  <= 1'b1;
      repeat (200)
      begin
         @(posedge clock);
         if (req.awvalid && rsp.awready)
            req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready)
            req.wvalid <= 1'b0;
         if (rsp.bvalid)
         begin
            rd_resp = rsp.bresp;
            req.bready <= 1'b0;
            return;
         end
      end
      to_fail();
   endtask : axi_wr
   task automatic axi_rd(input logic [3:0] idx);
      @(posedge clock);
      req.arvalid <= 1'b1;
      req.araddr  <= {26'h0, idx, 2'h0};
      req.rready  <= 1'b1;
      repeat (200)
      begin
         @(posedge clock);
         if (req.arvalid && rsp.arready)
            req.arvalid <= 1'b0;
         if (rsp.rvalid)
         begin
            rd_d = rsp.rdata;
            rd_resp = rsp.rresp;
            req.rready <= 1'b0;
            return;
         end
      end
      to_fail();
   endtask : axi_rd
   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      axi_wr(idx, d);
      `CHK(rd_resp, RESP_OKAY) // Write taken.
   endtask : wr
   task automatic rd_chk(input logic [3:0] idx, input logic [7:0] e);
      axi_rd(idx);
      `CHK(rd_resp, RESP_OKAY) // Read taken.
      `CHK(rd_d, {24'h0, e}) // Bit layout.
   endtask : rd_chk
   // ****************
   // Sequence
   // ****************
   initial
   begin
      tick(5);
      sys_rst <= 1'b0;
      tick(2);
      for (int i = 0; i < 9; i++)
         rd_chk(4'(i), 8'h00); // Reset values.
      axi_rd(4'h9);
      `CHK(rd_resp, RESP_SLVERR) // Unmapped read.
      `CHK(rd_d, 32'h0) // Unmapped data.
      axi_wr(4'h9, 8'hFF);
      `CHK(rd_resp, RESP_SLVERR) // Unmapped write.
      $display("test reset done");
      foreach (ROWS[i])
      begin
         wr(ROWS[i][19:16], ROWS[i][15:8]);
         rd_chk(ROWS[i][19:16], ROWS[i][7:0]); // Read as zero.
      end
      $display("test table done");
      for (int c = 0; c < 8; c++)
      begin
         wd = {3'h0, 1'(c), 1'(c >> 1), 3'(c)};
         lsr_en <= 1'(c >> 2);
         wr(IDX_MON, wd);
         tick(2);
         `CHK(mon.threshold_select, 3'(c)) // Code copied.
         `CHK(mon.monitor_active, wd[4]) // Enable.
         `CHK(mon.reference_buffer_enable, wd[4] | wd[3] | lsr_en)
         rd_chk(IDX_MON, wd); // Field kept.
         sleep <= 1'b1;
         tick(2);
         `CHK(mon.monitor_active, 1'b0) // Sleep off.
         sleep <= 1'b0;
      end
      lsr_en <= 1'b0;
      $display("test threshold done");
      for (int i = 0; i < 15; i++)
      begin
         evt_cmd <= icsm_evt_type'(15'h4000 >> i);
         tick(1);
         evt_cmd <= '0;
         tick(3);
         rd_chk(EVS[i][11:8], EVS[i][7:0]); // Flag placed.
         wr(EVS[i][11:8], 8'h00);
      end
      $display("test events done");
      wr(IDX_GRP_A, 8'h01);
      evt_cmd <= icsm_evt_type'(15'h0200);
      tick(1);
      evt_cmd <= '0;
      tick(3);
      rd_chk(IDX_PRIM_B, 8'h20); // Group flag.
      `CHK(pend, 11'h000) // Not enabled.
      wr(IDX_PRIM_B, 8'h22);
      tick(3);
      `CHK(pend, 11'h010) // Enabled.
      `CHK(core_irq, 1'b0) // Global off.
      wr(IDX_PRIM_A, 8'h01);
      tick(3);
      `CHK(core_irq, 1'b1) // Global on.
      wr(IDX_GRP_A, 8'h00);
      wr(IDX_PRIM_B, 8'h00);
      wr(IDX_PRIM_A, 8'h00);
      rd_chk(IDX_PRIM_B, 8'h00); // Clear sticks.
      $display("test grouping done");
      for (int k = 0; k < 8; k++)
      begin
         wr(IDX_EDGE, 8'((k % 4) << (2 * (k / 4))));
         for (int e = 0; e < 2; e++)
         begin
            if (k < 4)
               pin_a_cmd <= 1'(1 - e);
            else
               pin_b_cmd <= 1'(1 - e);
            tick(8);
            wd = 8'(((k % 4) >> e) & 1) << (4 + k / 4);
            rd_chk(IDX_PRIM_A, wd); // Edge codes.
            wr(IDX_PRIM_A, 8'h00);
         end
      end
      $display("test pins done");
      wr(IDX_GRP_D, 8'h01);
      wr(IDX_PRIM_C, 8'h08);
      wr(IDX_MON, 8'h10);
      tick(SETTLE_CYC);
      w0 = wake_cnt;
      idle <= 1'b1;
      low_cmd <= 1'b1;
      n_cyc = 0;
      while (pend[10] !== 1'b1 && n_cyc < 300)
      begin
         @(posedge clock);
         n_cyc++;
      end
      if (n_cyc >= 300) to_fail();
      `CHK(n_cyc >= MON_DLY_CYC, 1'b1) // Not early.
      `CHK(n_cyc <= MON_DLY_CYC + 10, 1'b1) // Not late.
      `CHK(wake_cnt - w0, 1) // Wake once.
      rd_chk(IDX_MON, 8'h30); // Low seen.
      rd_chk(IDX_GRP_D, 8'h11); // Sub-source.
      low_cmd <= 1'b0;
      tick(6);
      rd_chk(IDX_MON, 8'h10); // Supply good.
      wr(IDX_GRP_D, 8'h01);
      repeat (2)
      begin
         low_cmd <= 1'b1;
         tick(30);
         low_cmd <= 1'b0;
         tick(5);
      end
      rd_chk(IDX_GRP_D, 8'h01); // Short dips ignored.
      // Preset flag to suppress the wake-up.
      wr(IDX_GRP_D, 8'h11);
      tick(3);
      w0 = wake_cnt;
      low_cmd <= 1'b1;
      tick(80);
      `CHK(wake_cnt - w0, 0) // No wake.
      sleep <= 1'b1;
      tick(4);
      rd_chk(IDX_MON, 8'h10); // Held off.
      sleep <= 1'b0;
      idle <= 1'b0;
      $display("test monitor done");
      sys_rst <= 1'b1;
      tick(2);
      sys_rst <= 1'b0;
      tick(2);
      `CHK(mon, 5'h00) // Off after reset.
      `CHK(pend, 11'h000) // Flags cleared.
      rd_chk(IDX_MON, 8'h00); // Reset value.
      rd_chk(IDX_GRP_D, 8'h00); // Reset value.
      $display("test second reset done");
      end_sim();
   end
endmodule : irq_ctrl_with_supply_monitor_tb
